// ### core/emsc_pkg.sv
// shared constants and types for the external memory select and clock block
package emsc_pkg;

   // word address field that picks the memory space
   localparam int SPACE_FIELD_MSB = 31;
   localparam int SPACE_FIELD_LSB = 28;

   // space field codes that map to the four chip enables
   localparam logic [3:0] SPACE_CODE_0 = 4'h8;
   localparam logic [3:0] SPACE_CODE_1 = 4'h9;
   localparam logic [3:0] SPACE_CODE_2 = 4'ha;
   localparam logic [3:0] SPACE_CODE_3 = 4'hb;

   // access size encodings on the request port
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // values after reset, all active-low strobes idle high; STROBE_N_ALL drives both strobes low
   localparam logic [3:0] SELECT_N_RST = 4'hf;
   localparam logic [1:0] STROBE_N_RST = 2'h3;
   localparam logic [1:0] STROBE_N_ALL = 2'h0;

   // system clock and access strobe time
   localparam int SYS_CLK_NS = 50;
   localparam int ACCESS_NS = 200;
   localparam int ACCESS_CYCLES_DEF =
      (ACCESS_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

   // half periods of the two clock dividers, in source clock cycles
   localparam int INT_DIV_HALF_DEF = 1;
   localparam int EXT_DIV_HALF_DEF = 2;

   // access engine states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACCESS,
      ST_GRANTED
   } emsc_state_type;

endpackage : emsc_pkg

// ### core/emsc_ext_mem_ctrl.sv
// memory space select, byte strobes, bus release and interface clock out
`timescale 1ns/1ns

module emsc_ext_mem_ctrl #(
   parameter int ACCESS_CYCLES = emsc_pkg::ACCESS_CYCLES_DEF,
   parameter int INT_DIV_HALF = emsc_pkg::INT_DIV_HALF_DEF,
   parameter int EXT_DIV_HALF = emsc_pkg::EXT_DIV_HALF_DEF
) (
   input wire logic sys_clk_i, // system clock, 20 MHz
   input wire logic arst_n_i, // async reset, active low
   input wire logic mem_if_clock_input_i, // external interface clock
   input wire logic acc_req_i, // access request, taken with ready
   input wire logic [31:0] acc_word_addr_i, // word address of access
   input wire logic [1:0] acc_byte_addr_i, // low byte address bits
   input wire logic [1:0] acc_size_i, // byte, half or word
   input wire logic acc_write_i, // high for a write
   output logic acc_ready_o, // engine can take a request
   output logic acc_done_o, // access finished, one pulse
   output logic acc_err_o, // request refused, one pulse
   input wire logic mem_clock_source_select_i, // 0 internal, 1 input
   input wire logic mem_clock_output_gate_i, // 0 hold low, 1 run
   input wire logic bus_hold_req_i, // host bus request pin
   output logic bus_release_grant_o, // bus released to host
   output logic bus_need_indicator_o, // access waits for the bus
   output logic mem_space_select_0_n_o, // chip enable space 0
   output logic mem_space_select_1_n_o, // chip enable space 1
   output logic mem_space_select_2_n_o, // chip enable space 2
   output logic mem_space_select_3_n_o, // chip enable space 3
   output logic byte_strobe_0_n_o, // byte strobe, low lane
   output logic byte_strobe_1_n_o, // byte strobe, high lane
   output logic mem_ctrl_oe_o, // drive enable, selects and strobes
   output logic mem_if_clock_output_o // interface clock out
);

   // refuse settings the counters cannot serve
   if (ACCESS_CYCLES < 1 || ACCESS_CYCLES > 255) begin : g_chk_acc
      $error("ACCESS_CYCLES out of range");
   end
   if (INT_DIV_HALF < 1 || INT_DIV_HALF > 255) begin : g_chk_int
      $error("INT_DIV_HALF out of range");
   end
   if (EXT_DIV_HALF < 1 || EXT_DIV_HALF > 255) begin : g_chk_ext
      $error("EXT_DIV_HALF out of range");
   end

   localparam logic [7:0] ACC_LAST = 8'(ACCESS_CYCLES - 1);
   localparam logic [7:0] INT_LAST = 8'(INT_DIV_HALF - 1);
   localparam logic [7:0] EXT_LAST = 8'(EXT_DIV_HALF - 1);

   // one-hot active-low select from the space field
   function automatic logic [3:0] space_decode(input logic [3:0] code);
      logic [3:0] sel_n;
      sel_n = emsc_pkg::SELECT_N_RST;
      case (code)
         emsc_pkg::SPACE_CODE_0: sel_n = 4'he;
         emsc_pkg::SPACE_CODE_1: sel_n = 4'hd;
         emsc_pkg::SPACE_CODE_2: sel_n = 4'hb;
         emsc_pkg::SPACE_CODE_3: sel_n = 4'h7;
         default: sel_n = emsc_pkg::SELECT_N_RST;
      endcase
      return sel_n;
   endfunction : space_decode

   // active-low lane strobes; reads open both lanes so mask stays clear
   function automatic logic [1:0] lane_decode(input logic wr,
      input logic [1:0] size, input logic [1:0] ba);
      logic [1:0] be_n;
      be_n = emsc_pkg::STROBE_N_ALL;
      if (wr && size == emsc_pkg::SIZE_BYTE) begin
         be_n = ba[0] ? 2'h1 : 2'h2;
      end
      return be_n;
   endfunction : lane_decode

   // alignment check on the two low byte address bits
   function automatic logic misaligned(input logic [1:0] size,
      input logic [1:0] ba);
      logic bad;
      bad = 1'b0;
      case (size)
         emsc_pkg::SIZE_BYTE: bad = 1'b0;
         emsc_pkg::SIZE_HALF: bad = ba[0];
         emsc_pkg::SIZE_WORD: bad = (ba != 2'h0);
         default: bad = 1'b1;
      endcase
      return bad;
   endfunction : misaligned

   // ---------------- link domain: divider of the input clock
   logic link_src_s1_reg, link_src_s1_next;
   logic link_src_s2_reg, link_src_s2_next;
   logic link_div_reg, link_div_next;
   logic [7:0] link_cnt_reg, link_cnt_next;

   // divider runs only while the input clock is the chosen source
   always_comb begin
      link_src_s1_next = mem_clock_source_select_i;
      link_src_s2_next = link_src_s1_reg;
      link_div_next = link_div_reg;
      link_cnt_next = link_cnt_reg;
      if (!link_src_s2_reg) begin
         link_div_next = 1'b0;
         link_cnt_next = 8'h00;
      end else if (link_cnt_reg == EXT_LAST) begin
         link_div_next = ~link_div_reg;
         link_cnt_next = 8'h00;
      end else begin
         link_cnt_next = link_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge mem_if_clock_input_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link_src_s1_reg <= 1'b0;
         link_src_s2_reg <= 1'b0;
         link_div_reg <= 1'b0;
         link_cnt_reg <= 8'h00;
      end else begin
         link_src_s1_reg <= link_src_s1_next;
         link_src_s2_reg <= link_src_s2_next;
         link_div_reg <= link_div_next;
         link_cnt_reg <= link_cnt_next;
      end
   end

   // ---------------- system domain: clock out selection and gating
   // the divided input clock is a slow level, two flops bring it across;
   // the divider keeps it well below the sampling rate so no edge is lost
   logic ext_s1_reg, ext_s1_next;
   logic ext_s2_reg, ext_s2_next;
   logic int_div_reg, int_div_next;
   logic [7:0] int_cnt_reg, int_cnt_next;
   logic clk_out_reg, clk_out_next;

   always_comb begin
      ext_s1_next = link_div_reg;
      ext_s2_next = ext_s1_reg;
      int_div_next = int_div_reg;
      int_cnt_next = int_cnt_reg;
      // internal clock stand-in, divided from the system clock
      if (int_cnt_reg == INT_LAST) begin
         int_div_next = ~int_div_reg;
         int_cnt_next = 8'h00;
      end else begin
         int_cnt_next = int_cnt_reg + 8'h01;
      end
      // gate wins over source; output parks low when gated
      if (!mem_clock_output_gate_i) begin
         clk_out_next = 1'b0;
      end else if (mem_clock_source_select_i) begin
         clk_out_next = ext_s2_reg;
      end else begin
         clk_out_next = int_div_reg;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         int_div_reg <= 1'b0;
         int_cnt_reg <= 8'h00;
         clk_out_reg <= 1'b0;
      end else begin
         ext_s1_reg <= ext_s1_next;
         ext_s2_reg <= ext_s2_next;
         int_div_reg <= int_div_next;
         int_cnt_reg <= int_cnt_next;
         clk_out_reg <= clk_out_next;
      end
   end

   // ---------------- system domain: access engine and bus release
   logic hold_s1_reg, hold_s2_reg;
   emsc_pkg::emsc_state_type state_reg, state_next;
   logic [7:0] acc_cnt_reg, acc_cnt_next;
   logic [3:0] sel_n_reg, sel_n_next;
   logic [1:0] be_n_reg, be_n_next;
   logic oe_reg, oe_next;
   logic ready_reg, ready_next;
   logic done_reg, done_next;
   logic err_reg, err_next;
   logic grant_reg, grant_next;
   logic need_reg, need_next;
   logic [3:0] req_sel_n;
   logic req_bad;

   // decode of the offered request, used only on acceptance
   assign req_sel_n = space_decode(
      acc_word_addr_i[emsc_pkg::SPACE_FIELD_MSB:emsc_pkg::SPACE_FIELD_LSB]);
   assign req_bad = misaligned(acc_size_i, acc_byte_addr_i)
      || (req_sel_n == emsc_pkg::SELECT_N_RST);

   // a request already promised by ready wins over a new hold;
   // hold is then served once that access has ended
   always_comb begin
      state_next = state_reg;
      acc_cnt_next = acc_cnt_reg;
      sel_n_next = sel_n_reg;
      be_n_next = be_n_reg;
      oe_next = oe_reg;
      done_next = 1'b0;
      err_next = 1'b0;
      grant_next = grant_reg;
      need_next = 1'b0;
      case (state_reg)
         emsc_pkg::ST_IDLE: begin
            if (acc_req_i && ready_reg) begin
               if (req_bad) begin
                  err_next = 1'b1;
               end else begin
                  state_next = emsc_pkg::ST_ACCESS;
                  acc_cnt_next = ACC_LAST;
                  sel_n_next = req_sel_n;
                  be_n_next = lane_decode(acc_write_i, acc_size_i,
                     acc_byte_addr_i);
               end
            end else if (hold_s2_reg) begin
               state_next = emsc_pkg::ST_GRANTED;
               oe_next = 1'b0;
               grant_next = 1'b1;
            end
         end
         emsc_pkg::ST_ACCESS: begin
            if (acc_cnt_reg == 8'h00) begin
               state_next = emsc_pkg::ST_IDLE;
               sel_n_next = emsc_pkg::SELECT_N_RST;
               be_n_next = emsc_pkg::STROBE_N_RST;
               done_next = 1'b1;
            end else begin
               acc_cnt_next = acc_cnt_reg - 8'h01;
            end
         end
         emsc_pkg::ST_GRANTED: begin
            need_next = acc_req_i;
            if (!hold_s2_reg) begin
               state_next = emsc_pkg::ST_IDLE;
               oe_next = 1'b1;
               grant_next = 1'b0;
               need_next = 1'b0;
            end
         end
         default: begin
            state_next = emsc_pkg::ST_IDLE;
            sel_n_next = emsc_pkg::SELECT_N_RST;
            be_n_next = emsc_pkg::STROBE_N_RST;
            oe_next = 1'b1;
            grant_next = 1'b0;
         end
      endcase
      // ready only when next cycle idles with no hold pending
      ready_next = (state_next == emsc_pkg::ST_IDLE) && !hold_s2_reg;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         hold_s1_reg <= 1'b0;
         hold_s2_reg <= 1'b0;
         state_reg <= emsc_pkg::ST_IDLE;
         acc_cnt_reg <= 8'h00;
         sel_n_reg <= emsc_pkg::SELECT_N_RST;
         be_n_reg <= emsc_pkg::STROBE_N_RST;
         oe_reg <= 1'b1;
         ready_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
         grant_reg <= 1'b0;
         need_reg <= 1'b0;
      end else begin
         hold_s1_reg <= bus_hold_req_i; // pin, two-flop sync
         hold_s2_reg <= hold_s1_reg;
         state_reg <= state_next;
         acc_cnt_reg <= acc_cnt_next;
         sel_n_reg <= sel_n_next;
         be_n_reg <= be_n_next;
         oe_reg <= oe_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
         err_reg <= err_next;
         grant_reg <= grant_next;
         need_reg <= need_next;
      end
   end

   // outputs straight from flops
   assign acc_ready_o = ready_reg;
   assign acc_done_o = done_reg;
   assign acc_err_o = err_reg;
   assign bus_release_grant_o = grant_reg;
   assign bus_need_indicator_o = need_reg;
   assign mem_space_select_0_n_o = sel_n_reg[0];
   assign mem_space_select_1_n_o = sel_n_reg[1];
   assign mem_space_select_2_n_o = sel_n_reg[2];
   assign mem_space_select_3_n_o = sel_n_reg[3];
   assign byte_strobe_0_n_o = be_n_reg[0];
   assign byte_strobe_1_n_o = be_n_reg[1];
   assign mem_ctrl_oe_o = oe_reg;
   assign mem_if_clock_output_o = clk_out_reg;

endmodule : emsc_ext_mem_ctrl

// ### dv/emsc_chk.sv
// assertion checker for the memory select and clock block
`timescale 1ns/1ns
module emsc_chk #(
   parameter int ACCESS_CYCLES = 4
) (
   input wire logic sys_clk_i, // clock
   input wire logic arst_n_i, // reset
   input wire logic acc_req_i, // request
   input wire logic [31:0] acc_word_addr_i, // word address
   input wire logic [1:0] acc_byte_addr_i, // byte bits
   input wire logic [1:0] acc_size_i, // size
   input wire logic acc_write_i, // write
   input wire logic acc_ready_o, // ready
   input wire logic acc_done_o, // done
   input wire logic acc_err_o, // refused
   input wire logic mem_clock_source_select_i, // source
   input wire logic mem_clock_output_gate_i, // gate
   input wire logic bus_hold_req_i, // host pin
   input wire logic bus_release_grant_o, // grant
   input wire logic mem_ctrl_oe_o, // drive enable
   input wire logic mem_space_select_0_n_o, // select 0
   input wire logic mem_space_select_1_n_o, // select 1
   input wire logic mem_space_select_2_n_o, // select 2
   input wire logic mem_space_select_3_n_o, // select 3
   input wire logic byte_strobe_0_n_o, // strobe 0
   input wire logic byte_strobe_1_n_o, // strobe 1
   input wire logic mem_if_clock_output_o // clock out
);
   localparam int DONE_AT = ACCESS_CYCLES + 1;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   logic [3:0] sel_n;
   logic take;
   logic legal;
   logic bytew;
   // request decode, mirrors what the engine may accept
   assign sel_n = {mem_space_select_3_n_o, mem_space_select_2_n_o,
      mem_space_select_1_n_o, mem_space_select_0_n_o};
   assign take = acc_req_i && acc_ready_o;
   assign bytew = acc_write_i && acc_size_i == emsc_pkg::SIZE_BYTE;
   assign legal = acc_word_addr_i[31:28] inside {4'h8, 4'h9, 4'ha, 4'hb}
      && acc_size_i != 2'h3 && !(acc_size_i == 2'h1 && acc_byte_addr_i[0])
      && !(acc_size_i == 2'h2 && acc_byte_addr_i != 2'h0);
   sequence s_taken;
      take && legal;
   endsequence
   sequence s_ended;
      ##DONE_AT acc_done_o && sel_n == 4'hf;
   endsequence
   property p_space;
      s_taken |=> sel_n == ~(4'h1 << ($past(acc_word_addr_i[31:28]) - 4'h8));
   endproperty
   a_space: assert property (p_space) else $error("bad select");
   property p_refuse;
      take && !legal |=> acc_err_o && sel_n == 4'hf;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad refuse");
   property p_one;
      $onehot0(~sel_n);
   endproperty
   a_one: assert property (p_one) else $error("two selects low");
   property p_done;
      s_taken |-> s_ended;
   endproperty
   a_done: assert property (p_done) else $error("access end late");
   property p_lane;
      s_taken ##0 bytew |=> {byte_strobe_1_n_o, byte_strobe_0_n_o} ==
         {~$past(acc_byte_addr_i[0]), $past(acc_byte_addr_i[0])};
   endproperty
   a_lane: assert property (p_lane) else $error("byte lane wrong");
   property p_mask;
      s_taken ##0 !bytew |=> {byte_strobe_1_n_o, byte_strobe_0_n_o} == 2'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("mask not clear");
   property p_intclk;
      (mem_clock_output_gate_i && !mem_clock_source_select_i)[*3]
         |-> mem_if_clock_output_o != $past(mem_if_clock_output_o);
   endproperty
   a_intclk: assert property (p_intclk) else $error("no toggle");
   property p_gate;
      !mem_clock_output_gate_i |=> !mem_if_clock_output_o;
   endproperty
   a_gate: assert property (p_gate) else $error("clock not held");
   property p_grant;
      (bus_hold_req_i && !acc_req_i)[*8] |-> bus_release_grant_o;
   endproperty
   a_grant: assert property (p_grant) else $error("no grant");
   property p_float;
      bus_release_grant_o |-> !mem_ctrl_oe_o && sel_n == 4'hf
         && $past(bus_hold_req_i, 3);
   endproperty
   a_float: assert property (p_float) else $error("bad release");
endmodule : emsc_chk

bind emsc_ext_mem_ctrl emsc_chk #(.ACCESS_CYCLES(ACCESS_CYCLES)) chk (.*);

// ### dv/emsc_host_model.sv
// host model that asks for the external bus and gives it back
`timescale 1ns/1ns
module emsc_host_model (
   input wire logic sys_clk_i, // system clock
   input wire logic want_i, // bench asks the host to take the bus
   input wire logic grant_i, // grant from the device
   output logic hold_o, // bus request pin toward the device
   output int held_o // cycles the bus was held
);
   initial begin
      hold_o = 1'b0;
      held_o = 0;
   end
   // pin moves just after the edge, like a real host output
   always @(posedge sys_clk_i) begin
      hold_o <= #2 want_i;
      if (grant_i && hold_o) held_o <= held_o + 1;
   end
endmodule : emsc_host_model

// ### dv/tb_top.sv
// self-checking bench for the memory select and clock block
`timescale 1ns/1ns
module tb_top;
   localparam int ACC = 4;
   logic sys_clk_i = 1'b0, arst_n_i = 1'b0, mem_if_clock_input_i = 1'b0;
   logic acc_req_i = 1'b0, acc_write_i = 1'b0, want = 1'b0;
   logic [31:0] acc_word_addr_i = 32'h0, rng = 32'hf5eb;
   logic [1:0] acc_byte_addr_i = 2'h0, acc_size_i = 2'h0;
   logic mem_clock_source_select_i = 1'b0, mem_clock_output_gate_i = 1'b0;
   logic bus_hold_req_i, acc_ready_o, acc_done_o, acc_err_o, prev;
   logic bus_release_grant_o, bus_need_indicator_o, mem_ctrl_oe_o;
   logic mem_if_clock_output_o, byte_strobe_0_n_o, byte_strobe_1_n_o;
   logic mem_space_select_0_n_o, mem_space_select_1_n_o;
   logic mem_space_select_2_n_o, mem_space_select_3_n_o;
   int mismatches = 0, checks_done = 0, held, n;
   wire [3:0] sel_n = {mem_space_select_3_n_o, mem_space_select_2_n_o,
      mem_space_select_1_n_o, mem_space_select_0_n_o};
   always #25 sys_clk_i = ~sys_clk_i;
   // link clock free running, phase unrelated to the system clock
   initial #7 forever #16 mem_if_clock_input_i = ~mem_if_clock_input_i;
   emsc_ext_mem_ctrl #(.ACCESS_CYCLES(ACC)) uut (.*);
   emsc_host_model host (.sys_clk_i(sys_clk_i), .want_i(want),
      .grant_i(bus_release_grant_o), .hold_o(bus_hold_req_i), .held_o(held));
   function automatic logic [31:0] xs(logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction : xs
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize
   task automatic compare(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (exp !== got) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : compare
   // inputs always move 2 ns after the rising edge
   task automatic tick(int k);
      repeat (k) @(posedge sys_clk_i);
      #2;
   endtask : tick
   // bounded wait: 0 ready high, 1 grant high, 2 grant low
   task automatic await(int which, int lim);
      int k;
      k = 0;
      while (k < lim && !((which == 0 && acc_ready_o === 1'b1) ||
         (which == 1 && bus_release_grant_o === 1'b1) ||
         (which == 2 && bus_release_grant_o === 1'b0))) begin
         tick(1);
         k++;
      end
      if (k == lim) begin
         mismatches++;
         $display("wrong value wait %0d expected 1 seen 0", which);
         summarize();
      end
   endtask : await
   task automatic access(logic [3:0] fld, logic [1:0] ba, logic [1:0] sz,
      logic wr);
      logic ok;
      logic [3:0] sel;
      logic [1:0] stb;
      ok = fld >= 4'h8 && fld <= 4'hb && sz != 2'h3 &&
         !(sz == 2'h1 && ba[0]) && !(sz == 2'h2 && ba != 2'h0);
      sel = ok ? ~(4'h1 << (fld - 4'h8)) : 4'hf;
      stb = (wr && sz == 2'h0) ? {~ba[0], ba[0]} : 2'h0;
      await(0, 20);
      rng = xs(rng);
      acc_word_addr_i = {fld, rng[27:0]};
      acc_byte_addr_i = ba;
      acc_size_i = sz;
      acc_write_i = wr;
      acc_req_i = 1'b1;
      tick(1);
      acc_req_i = 1'b0;
      compare("select", {28'h0, sel}, {28'h0, sel_n});
      compare("refused", {31'h0, !ok}, {31'h0, acc_err_o});
      compare("ready", {31'h0, !ok}, {31'h0, acc_ready_o});
      if (ok) begin
         compare("strobes", {30'h0, stb}, {30'h0, byte_strobe_1_n_o,
            byte_strobe_0_n_o});
         tick(ACC - 1);
         compare("held select", {28'h0, sel}, {28'h0, sel_n});
         tick(1);
         compare("done", 32'h1, {31'h0, acc_done_o});
      end else begin
         // let an edge pass so the request line is not raised again
         // in the same step it was dropped
         tick(1);
      end
   endtask : access
   initial begin
      tick(2);
      arst_n_i = 1'b1;
      tick(1);
      // every space code plus the refused neighbours
      for (int f = 7; f <= 12; f++) begin
         access(f[3:0], 2'h0, 2'h2, 1'b1);
      end
      for (int b = 0; b < 4; b++) access(4'h9, b[1:0], 2'h0, 1'b1);
      access(4'ha, 2'h1, 2'h1, 1'b1);
      access(4'hb, 2'h2, 2'h1, 1'b0);
      access(4'h8, 2'h0, 2'h3, 1'b0);
      repeat (24) begin
         rng = xs(rng);
         access(rng[31] ? 4'h7 : {2'h2, rng[5:4]}, rng[1:0], rng[3:2],
            rng[6]);
      end
      // output clock: held low, then internal, then from the link clock
      for (int i = 0; i < 6; i++) begin
         compare("gated", 32'h0, {31'h0, mem_if_clock_output_o});
         tick(1);
      end
      mem_clock_output_gate_i = 1'b1;
      tick(3);
      prev = mem_if_clock_output_o;
      for (int i = 0; i < 6; i++) begin
         tick(1);
         compare("internal", {31'h0, ~prev},
            {31'h0, mem_if_clock_output_o});
         prev = mem_if_clock_output_o;
      end
      mem_clock_source_select_i = 1'b1;
      tick(6);
      n = 0;
      // 40 cycles of 50 ns see about 31 edges of a 128 ns clock
      for (int i = 0; i < 40; i++) begin
         prev = mem_if_clock_output_o;
         tick(1);
         if (prev !== mem_if_clock_output_o) n++;
      end
      compare("link rate", 32'h1, {31'h0, n >= 27 && n <= 35});
      // host takes the bus, a request waits, host hands it back
      want = 1'b1;
      await(1, 12);
      compare("drive enable", 32'h0, {31'h0, mem_ctrl_oe_o});
      compare("ready granted", 32'h0, {31'h0, acc_ready_o});
      // pin held with no request long enough for the grant check
      tick(8);
      acc_word_addr_i = 32'h8000_0000;
      acc_size_i = 2'h2;
      acc_byte_addr_i = 2'h0;
      acc_req_i = 1'b1;
      tick(3);
      compare("need", 32'h1, {31'h0, bus_need_indicator_o});
      compare("floated", 32'hf, {28'h0, sel_n});
      acc_req_i = 1'b0;
      want = 1'b0;
      await(2, 12);
      compare("drive back", 32'h1, {31'h0, mem_ctrl_oe_o});
      compare("host held", 32'h1, {31'h0, held > 0});
      summarize();
   end
endmodule : tb_top
